// ==== hdl/timer_pkg.sv ====
// Constants, field layouts and carrier types of the 8-bit compare timer.
// Assumes a 32-bit classic Wishbone register bus and one 250 MHz clock.
package timer_pkg;

  // ==========================================================
  // Register offsets (byte addresses, one aligned word each)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_PORT = 8'h10;

  // ==========================================================
  // Field positions
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COM_LSB = 2;
  localparam int CTRL_CS_LSB = 4;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int FLAG_OC_BIT = 2;
  localparam int PORT_OUT_BIT = 0;
  localparam int PORT_DIR_BIT = 1;
  localparam int PORT_PIN_BIT = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic RST_BIT = 1'b0;

  // ==========================================================
  // Modes, output actions and count limits
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PWM_PHASE = 2'h1;
  localparam logic [1:0] WGM_CLEAR_ON_MATCH = 2'h2;
  localparam logic [1:0] WGM_PWM_FAST = 2'h3;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // ==========================================================
  // Prescaler taps: a tick when the masked prescaler bits are all one
  localparam int PRESC_W = 10;
  localparam logic [9:0] PRESC_MASK_8 = 10'h007;
  localparam logic [9:0] PRESC_MASK_32 = 10'h01F;
  localparam logic [9:0] PRESC_MASK_64 = 10'h03F;
  localparam logic [9:0] PRESC_MASK_128 = 10'h07F;
  localparam logic [9:0] PRESC_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRESC_MASK_1024 = 10'h3FF;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic [1:0] out_mode;
    logic [1:0] wave_mode;
  } ctrl_s;

  typedef struct packed {
    logic out_bit;
    logic dir_bit;
  } port_s;

  localparam ctrl_s RST_CTRL = '0;
  localparam port_s RST_PORT = '0;

endpackage

// ==== hdl/timer_compare_unit.sv ====
// 8-bit timer/counter with one compare channel and port-pin override.
// Assumes a classic Wishbone master on clk_i and a pad that resolves pin_o/pin_oe_n_o.
//
// Operation
// - A count write suppresses compare matches during the next timer clock.
// - Writing count equal to compare produces no match and no output action.
// - The output state keeps its value when the waveform mode changes.
// - Output mode is unbuffered and governs the first match after writing.
// - Nonzero output mode drives the pin from the waveform generator.
// - The pin is driven only while the direction bit selects output.
// - Pin override depends only on output mode, not waveform mode.
// - Output mode zero leaves the output state unchanged on a match.
// - In non-PWM modes the force strobe applies the action at once.
// - Non-PWM: set, clear or toggle on match; PWM: inverted, non-inverted or toggle on match.
// - Only the waveform mode decides the counting sequence.
// - Free-running mode counts up and wraps from 0xFF to 0x00.
// - Free-running overflow flag sets when the count becomes zero.
// - Servicing the overflow interrupt clears the overflow flag.
// - Clear-on-match mode clears the count after it equals compare.
// - Compare is unbuffered; below count, counter wraps through 0xFF first.
// - Clear-on-match raises the compare flag at each top.
// - Toggle action in clear-on-match toggles on every match.
// - Prescale is selectable among 1, 8, 32, 64, 128, 256 and 1024.
// - Clear-on-match overflow flag sets when the count wraps to 0x00.
// - Force updates the output state only, not flag or counter.
// - Match sets the flag at the timer tick; write-one or service clears.
// - A count write has priority over clear or count in that cycle.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps

module timer_compare_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [timer_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n_o,
  input wire logic overflow_service_i,
  input wire logic compare_service_i,
  output logic overflow_flag_o,
  output logic compare_match_flag_o
);
  import timer_pkg::*;

  // ==========================================================
  // State
  ctrl_s ctrl_ff;
  port_s port_ff;
  logic [7:0] timer_count_ff;
  logic [7:0] compare_value_ff;
  logic [PRESC_W-1:0] presc_ff;
  logic block_ff;
  logic compare_output_ff;
  logic overflow_flag_ff;
  logic compare_match_flag_ff;
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic pin_out_ff;
  logic pin_oe_n_ff;
  logic ack_ff;
  logic [31:0] dat_ff;

  logic bus_req;
  logic bus_wr;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic wr_port;
  logic timer_tick;
  logic tick_eff;
  logic equal_hit;
  logic at_max;
  logic pwm_mode;
  logic force_now;
  ctrl_s ctrl_new;
  logic [31:0] rd_word;

  // ==========================================================
  // Helpers
  function automatic logic hits(input logic [ADDR_W-1:0] adr, input logic [7:0] ofs);
    hits = (adr == ofs);
  endfunction

  function automatic logic tap(input logic [PRESC_W-1:0] p, input logic [PRESC_W-1:0] m);
    tap = ((p & m) == m);
  endfunction

  // Output action on a match or force; mode zero does nothing.
  function automatic logic oc_action(input logic [1:0] com, input logic oc);
    case (com)
      COM_TOGGLE: oc_action = ~oc;
      COM_CLEAR: oc_action = 1'b0;
      COM_SET: oc_action = 1'b1;
      default: oc_action = oc;
    endcase
  endfunction

  // ==========================================================
  // Bus decode
  // A request is taken in the cycle it is seen without a pending ack.
  assign bus_req = cyc_i & stb_i & ~ack_ff;
  assign bus_wr = bus_req & we_i & sel_i[0];
  assign wr_ctrl = bus_wr & hits(adr_i, OFS_CTRL);
  assign wr_count = bus_wr & hits(adr_i, OFS_COUNT);
  assign wr_compare = bus_wr & hits(adr_i, OFS_COMPARE);
  assign wr_flags = bus_wr & hits(adr_i, OFS_FLAGS);
  assign wr_port = bus_wr & hits(adr_i, OFS_PORT);

  assign ctrl_new.wave_mode = dat_i[CTRL_WGM_LSB +: 2];
  assign ctrl_new.out_mode = dat_i[CTRL_COM_LSB +: 2];
  assign ctrl_new.clk_sel = dat_i[CTRL_CS_LSB +: 3];

  // ==========================================================
  // Prescaler
  // The prescaler runs free so a new select takes effect on its next tap.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 10'h001;
    end
  end

  always_comb begin
    case (ctrl_ff.clk_sel)
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = tap(presc_ff, PRESC_MASK_8);
      3'h3: timer_tick = tap(presc_ff, PRESC_MASK_32);
      3'h4: timer_tick = tap(presc_ff, PRESC_MASK_64);
      3'h5: timer_tick = tap(presc_ff, PRESC_MASK_128);
      3'h6: timer_tick = tap(presc_ff, PRESC_MASK_256);
      3'h7: timer_tick = tap(presc_ff, PRESC_MASK_1024);
      default: timer_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // Compare and counter
  // A count write steals the tick so the written value is not counted away.
  assign tick_eff = timer_tick & ~wr_count;
  assign equal_hit = (timer_count_ff == compare_value_ff) & ~block_ff;
  assign at_max = (timer_count_ff == COUNT_MAX);
  assign pwm_mode = ctrl_ff.wave_mode[0];

  // The block persists while the timer is stopped, until one tick passes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_ff <= 1'b0;
    end else if (wr_count) begin
      block_ff <= 1'b1;
    end else if (timer_tick) begin
      block_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_count_ff <= RST_COUNT;
    end else if (wr_count) begin
      timer_count_ff <= dat_i[7:0];
    end else if (tick_eff) begin
      if (ctrl_ff.wave_mode == WGM_CLEAR_ON_MATCH && equal_hit) begin
        timer_count_ff <= COUNT_BOTTOM;
      end else begin
        timer_count_ff <= timer_count_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_value_ff <= RST_COMPARE;
    end else if (wr_compare) begin
      compare_value_ff <= dat_i[7:0];
    end
  end

  // ==========================================================
  // Control and port registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_ff <= ctrl_new;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_ff <= RST_PORT;
    end else if (wr_port) begin
      port_ff.out_bit <= dat_i[PORT_OUT_BIT];
      port_ff.dir_bit <= dat_i[PORT_DIR_BIT];
    end
  end

  // ==========================================================
  // Waveform generator
  // Force uses the mode being written, so one write can set and force.
  assign force_now = wr_ctrl & dat_i[CTRL_FORCE_BIT] & ~ctrl_new.wave_mode[0];

  // Mode changes never touch this register; only actions do.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_output_ff <= RST_BIT;
    end else if (force_now) begin
      compare_output_ff <= oc_action(ctrl_new.out_mode, compare_output_ff);
    end else if (tick_eff && equal_hit) begin
      compare_output_ff <= oc_action(ctrl_ff.out_mode, compare_output_ff);
    end else if (tick_eff && pwm_mode && at_max) begin
      if (ctrl_ff.out_mode == COM_CLEAR) begin
        compare_output_ff <= 1'b1;
      end else if (ctrl_ff.out_mode == COM_SET) begin
        compare_output_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Flags
  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_ff <= RST_BIT;
    end else if (tick_eff && at_max) begin
      overflow_flag_ff <= 1'b1;
    end else if (overflow_service_i || (wr_flags && dat_i[FLAG_OVF_BIT])) begin
      overflow_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_match_flag_ff <= RST_BIT;
    end else if (tick_eff && equal_hit) begin
      compare_match_flag_ff <= 1'b1;
    end else if (compare_service_i || (wr_flags && dat_i[FLAG_CMP_BIT])) begin
      compare_match_flag_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Pin
  // The pin level is double-flopped before software can read it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Registered pad drive costs one cycle of latency but keeps outputs glitch-free.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_ff <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end else begin
      if (ctrl_ff.out_mode != COM_NONE) begin
        pin_out_ff <= compare_output_ff;
      end else begin
        pin_out_ff <= port_ff.out_bit;
      end
      pin_oe_n_ff <= ~port_ff.dir_bit;
    end
  end

  // ==========================================================
  // Read data and acknowledge
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hits(adr_i, OFS_CTRL)) begin
      rd_word[CTRL_WGM_LSB +: 2] = ctrl_ff.wave_mode;
      rd_word[CTRL_COM_LSB +: 2] = ctrl_ff.out_mode;
      rd_word[CTRL_CS_LSB +: 3] = ctrl_ff.clk_sel;
    end else if (hits(adr_i, OFS_COUNT)) begin
      rd_word[7:0] = timer_count_ff;
    end else if (hits(adr_i, OFS_COMPARE)) begin
      rd_word[7:0] = compare_value_ff;
    end else if (hits(adr_i, OFS_FLAGS)) begin
      rd_word[FLAG_OVF_BIT] = overflow_flag_ff;
      rd_word[FLAG_CMP_BIT] = compare_match_flag_ff;
      rd_word[FLAG_OC_BIT] = compare_output_ff;
    end else if (hits(adr_i, OFS_PORT)) begin
      rd_word[PORT_OUT_BIT] = port_ff.out_bit;
      rd_word[PORT_DIR_BIT] = port_ff.dir_bit;
      rd_word[PORT_PIN_BIT] = pin_sync_ff;
    end
  end

  // Unmapped addresses are acknowledged, read as zero and ignore writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req;
      if (bus_req && !we_i) begin
        dat_ff <= rd_word;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign dat_o = dat_ff;
  assign ack_o = ack_ff;
  assign pin_o = pin_out_ff;
  assign pin_oe_n_o = pin_oe_n_ff;
  assign overflow_flag_o = overflow_flag_ff;
  assign compare_match_flag_o = compare_match_flag_ff;

endmodule

// ==== verif/port_pad_model.sv ====
// Pad model for the compare pin: resolves the driven level and feeds it back.
// Assumes pin_oe_n_o low means the block drives the pad.
`timescale 1ns/100ps
module port_pad_model (
  input wire logic clk_i,
  input wire logic pin_o,
  input wire logic pin_oe_n_o,
  output logic pin_i
);
  // The pad has no pull, so an undriven pin shows a changing level, never a held one.
  logic alt_ff = 1'b0;
  always_ff @(posedge clk_i) begin
    alt_ff <= ~alt_ff;
  end
  assign pin_i = pin_oe_n_o ? alt_ff : pin_o;
endmodule

// ==== verif/timer_compare_unit_chk.sv ====
// Port assertions for the compare timer: bus answers, pin source and flag hold.
// Assumes it is bound to timer_compare_unit; shadows follow accepted bus writes.
`timescale 1ns/100ps
module timer_compare_unit_chk
  import timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [timer_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic pin_i,
  input wire logic pin_o,
  input wire logic pin_oe_n_o,
  input wire logic overflow_service_i,
  input wire logic compare_service_i,
  input wire logic overflow_flag_o,
  input wire logic compare_match_flag_o
);
  logic take;
  logic wr0;
  logic [1:0] mode_sh_ff;
  logic out_sh_ff;
  logic dir_sh_ff;
  assign take = cyc_i && stb_i && !ack_o;
  assign wr0 = take && we_i && sel_i[0];
  // ====
  // Shadows of the fields that steer the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_sh_ff <= COM_NONE;
    end else if (wr0 && adr_i == OFS_CTRL) begin
      mode_sh_ff <= dat_i[CTRL_COM_LSB +: 2];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_sh_ff <= 1'b0;
      dir_sh_ff <= 1'b0;
    end else if (wr0 && adr_i == OFS_PORT) begin
      out_sh_ff <= dat_i[PORT_OUT_BIT];
      dir_sh_ff <= dat_i[PORT_DIR_BIT];
    end
  end
  // ====
  // Assertions.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_answers: assert property (take |=> ack_o)
    else $error("no ack after a request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (ack_o |-> $past(take))
    else $error("ack without a request");
  chk_unmapped_zero: assert property (take && !we_i && adr_i > OFS_PORT |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_force_reads_zero: assert property (take && !we_i && adr_i == OFS_CTRL |=> !dat_o[CTRL_FORCE_BIT])
    else $error("force strobe reads back set");
  chk_pin_direction: assert property (!$past(rst_i) |-> pin_oe_n_o == !$past(dir_sh_ff))
    else $error("pin enable does not follow direction");
  chk_pin_port_src: assert property (!$past(rst_i) && $past(mode_sh_ff) == COM_NONE |-> pin_o == $past(out_sh_ff))
    else $error("pin not from port bit with no output mode");
  chk_reset_idle: assert property ($fell(rst_i) |-> pin_oe_n_o && !pin_o && !overflow_flag_o && !compare_match_flag_o)
    else $error("outputs not idle after reset");
  chk_ovf_hold: assert property ($fell(overflow_flag_o) && !$past(rst_i) |->
    $past(overflow_service_i || (wr0 && adr_i == OFS_FLAGS && dat_i[FLAG_OVF_BIT])))
    else $error("overflow flag cleared without cause");
  chk_cmp_hold: assert property ($fell(compare_match_flag_o) && !$past(rst_i) |->
    $past(compare_service_i || (wr0 && adr_i == OFS_FLAGS && dat_i[FLAG_CMP_BIT])))
    else $error("compare flag cleared without cause");
endmodule
bind timer_compare_unit timer_compare_unit_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .overflow_service_i(overflow_service_i),
  .compare_service_i(compare_service_i), .overflow_flag_o(overflow_flag_o),
  .compare_match_flag_o(compare_match_flag_o));

// ==== verif/test_timer_compare_unit.sv ====
// Bench for the compare timer: random runs in free-running and clear-on-match modes.
// Assumes the pad model closes the pin loop and the checker is bound to the design.
`timescale 1ns/100ps
module test_timer_compare_unit;
  import timer_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, pin_i, pin_o, pin_oe_n_o, ovf_flag, cmp_flag;
  logic ovf_srv = 1'b0, cmp_srv = 1'b0;
  logic [7:0] m_cnt;
  logic m_ovf, m_cmpf, m_st;
  int num_errors = 0, samples_checked = 0, seed = 32'h5895, cyc_now = 0, ack_cyc = 0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_now <= cyc_now + 1;
  timer_compare_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .overflow_service_i(ovf_srv), .compare_service_i(cmp_srv),
    .overflow_flag_o(ovf_flag), .compare_match_flag_o(cmp_flag));
  port_pad_model i_pad (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pin_i(pin_i));
  // ====
  // Reporting and bus tasks.
  task automatic conclude();
    $display("Counts: %0d checked, %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      n++;
      if (n > 100) begin
        num_errors++;
        conclude();
      end
      @(posedge clk_i);
    end
    q = dat_o;
    ack_cyc = cyc_now;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  // ====
  // Reference model of the counter, flags and output state.
  function automatic logic act(input logic [1:0] om, input logic s);
    case (om)
      COM_TOGGLE: return !s;
      COM_CLEAR: return 1'b0;
      COM_SET: return 1'b1;
      default: return s;
    endcase
  endfunction
  // The first tick after a count write never matches, even after a stop.
  function automatic void run(input logic [1:0] wm, input logic [1:0] om, input logic [7:0] cmp, input int n);
    logic hit;
    for (int i = 0; i < n; i++) begin
      hit = (m_cnt == cmp) && (i != 0);
      m_cmpf = m_cmpf | hit;
      m_st = hit ? act(om, m_st) : m_st;
      m_ovf = m_ovf | (m_cnt == COUNT_MAX);
      m_cnt = (hit && wm == WGM_CLEAR_ON_MATCH) ? COUNT_BOTTOM : m_cnt + 8'h01;
    end
  endfunction
  // Ticks between two acks; the prescaler counts from zero at the third edge, just after reset release.
  function automatic int tick_count(input logic [2:0] cs, input int s, input int e);
    int div;
    int k;
    k = 0;
    div = (cs == 3'h1) ? 1 : (cs == 3'h2) ? 8 : (cs == 3'h3) ? 32 : 64;
    for (int j = s + 1; j <= e; j++) begin
      if ((j - 3) % div == div - 1) begin
        k++;
      end
    end
    return k;
  endfunction
  initial begin
    logic [1:0] wm, om;
    logic [7:0] cmp, cnt;
    logic [2:0] cs;
    logic po;
    int n, s, nt;
    m_st = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a <= 20; a += 4) begin
      if (a != 16) rd(8'(a), 32'h0);
    end
    check(32'({pin_oe_n_o, pin_o}), 32'h2);
    sel_i <= 4'hE;
    wr(OFS_COMPARE, 32'h0000_005A);
    sel_i <= 4'hF;
    rd(OFS_COMPARE, 32'h0);
    wr(OFS_CTRL, {24'h0, 1'b1, 3'h0, COM_SET, WGM_NORMAL});
    wr(OFS_CTRL, {24'h0, 1'b1, 3'h0, COM_TOGGLE, WGM_PWM_FAST});
    m_st = 1'b1;
    rd(OFS_FLAGS, 32'h4);
    $display("Test reset done");
    for (int t = 0; t < 40; t++) begin
      wm = ($random(seed) & 1) ? WGM_CLEAR_ON_MATCH : WGM_NORMAL;
      om = 2'($random(seed));
      cmp = (t % 4 == 0) ? 8'h00 : 8'($random(seed));
      cnt = (t % 3 == 0) ? cmp : 8'($random(seed));
      n = 1 + ($random(seed) & 511);
      po = 1'($random(seed));
      wr(OFS_CTRL, {24'h0, 1'b0, 3'h0, om, wm});
      wr(OFS_FLAGS, 32'h3);
      wr(OFS_COMPARE, {24'h0, cmp});
      m_st = act(om, m_st);
      wr(OFS_CTRL, {24'h0, 1'b1, 3'h0, om, wm});
      rd(OFS_FLAGS, {29'h0, m_st, 2'b00});
      wr(OFS_PORT, {30'h0, 1'b1, po});
      // Neither mode used here counts down, so a zero load is always safe.
      wr(OFS_COUNT, {24'h0, cnt});
      m_cnt = cnt;
      m_ovf = 1'b0;
      m_cmpf = 1'b0;
      cs = 3'(1 + ($random(seed) & 3));
      wr(OFS_CTRL, {24'h0, 1'b0, cs, om, wm});
      s = ack_cyc;
      repeat (n) @(posedge clk_i);
      wr(OFS_CTRL, {24'h0, 1'b0, 3'h0, om, wm});
      nt = tick_count(cs, s, ack_cyc);
      run(wm, om, cmp, nt);
      rd(OFS_COUNT, {24'h0, m_cnt});
      rd(OFS_FLAGS, {29'h0, m_st, m_cmpf, m_ovf});
      check(32'({pin_oe_n_o, pin_o, ovf_flag, cmp_flag}), 32'({1'b0, (om != COM_NONE) ? m_st : po, m_ovf, m_cmpf}));
      rd(OFS_PORT, {29'h0, (om != COM_NONE) ? m_st : po, 1'b1, po});
      ovf_srv <= 1'b1;
      cmp_srv <= 1'b1;
      @(posedge clk_i);
      ovf_srv <= 1'b0;
      cmp_srv <= 1'b0;
      @(posedge clk_i);
      check(32'({ovf_flag, cmp_flag}), 32'h0);
      $display("Test %0d done: mode %0d, action %0d, select %0d, %0d ticks", t, wm, om, cs, nt);
    end
    conclude();
  end
endmodule
